// ==== hw/rrnc_pkg.sv ====
/*
 * Package for the rotate-right-without-carry execution datapath.
 * Assumes a single core clock and no software-visible registers.
 */
package rrnc_pkg;
    localparam int RRNC_DATA_W = 8;
    localparam int RRNC_ADDR_W = 12;
    localparam int RRNC_BANK_W = 4;
    localparam logic [7:0] RRNC_ILO_LIMIT = 8'h5F;
    localparam logic [7:0] RRNC_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] RRNC_ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0] RRNC_W_RESET = 8'h00;
    localparam logic [7:0] RRNC_BANK_RESET = 8'h00;
    localparam int RRNC_MSB_POS = 7;
    localparam int RRNC_LSB_POS = 0;
    typedef enum logic [1:0] {
        RRNC_Q1_DECODE,
        RRNC_Q2_READ,
        RRNC_Q3_PROCESS,
        RRNC_Q4_WRITE
    } rrnc_phase_t;
endpackage

// ==== hw/rrnc_rotate.sv ====
/*
 * Combinational rotate-right-by-one with the N and Z flag terms.
 * Assumes the caller registers the outputs.
 */
module rrnc_rotate
    import rrnc_pkg::*;
#(
    parameter int WIDTH = RRNC_DATA_W
) (
    input wire logic [WIDTH-1:0] operand,
    output logic [WIDTH-1:0] result,
    output logic neg,
    output logic zero
);
    always_comb begin
        result = {operand[0], operand[WIDTH-1:1]};
        neg = result[WIDTH-1];
        zero = (result == '0);
    end
endmodule // rrnc_rotate

// ==== hw/rrnc_exec.sv ====
/*
 * Execution unit for the rotate-right-without-carry instruction.
 * Assumes the data memory answers a read in the same phase it is asked
 * and that the instruction word is held stable while start is pulsed.
 */
module rrnc_exec
    import rrnc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic rotate_right_nocarry_op,
    input wire logic [7:0] f_addr,
    input wire logic dest_sel,
    input wire logic access_sel,
    input wire logic ext_set_en,
    input wire logic [RRNC_BANK_W-1:0] bank_select_reg,
    input wire logic [RRNC_ADDR_W-1:0] index_base,
    input wire logic [7:0] mem_rdata,
    output logic busy,
    output logic [RRNC_ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic [7:0] w_reg,
    output logic n_flag,
    output logic z_flag,
    output logic flag_we,
    output logic done
);
    rrnc_phase_t phase_q, phase_d;
    logic active_q, active_d;
    logic dest_q, dest_d;
    logic [RRNC_ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] res_q, res_d;
    logic n_q, n_d, z_q, z_d;
    logic [7:0] w_q, w_d;
    logic [7:0] wdata_q, wdata_d;
    logic wr_q, wr_d, fwe_q, fwe_d, done_q, done_d;
    logic [7:0] rot_res;
    logic rot_n, rot_z;
    logic [RRNC_ADDR_W-1:0] eff_addr;

    rrnc_rotate #(.WIDTH(RRNC_DATA_W)) u_rot (
        .operand(opnd_q),
        .result(rot_res),
        .neg(rot_n),
        .zero(rot_z)
    );

    // Address is formed at decode so the read phase sees a stable value.
    always_comb begin
        if (!access_sel && ext_set_en && f_addr <= RRNC_ILO_LIMIT) begin
            eff_addr = index_base + RRNC_ADDR_W'(f_addr);
        end else if (!access_sel) begin
            eff_addr = (f_addr < RRNC_ACCESS_SPLIT) ? {4'h0, f_addr}
                                                    : {RRNC_ACCESS_HI_BANK, f_addr};
        end else begin
            eff_addr = {bank_select_reg, f_addr};
        end
    end

    always_comb begin
        phase_d = phase_q;
        active_d = active_q;
        dest_d = dest_q;
        addr_d = addr_q;
        opnd_d = opnd_q;
        res_d = res_q;
        n_d = n_q;
        z_d = z_q;
        w_d = w_q;
        wdata_d = wdata_q;
        wr_d = 1'b0;
        fwe_d = 1'b0;
        done_d = 1'b0;
        // A start that comes while an instruction is running is dropped without any sign.
        // The caller must wait for done, which costs nothing since decode follows at once.
        case (phase_q)
            RRNC_Q1_DECODE: begin
                if (start && rotate_right_nocarry_op) begin
                    active_d = 1'b1;
                    dest_d = dest_sel;
                    addr_d = eff_addr;
                    phase_d = RRNC_Q2_READ;
                end
            end
            RRNC_Q2_READ: begin
                opnd_d = mem_rdata;
                phase_d = RRNC_Q3_PROCESS;
            end
            RRNC_Q3_PROCESS: begin
                // Flags load one phase early; a consumer must qualify them with flag_we.
                res_d = rot_res;
                n_d = rot_n;
                z_d = rot_z;
                phase_d = RRNC_Q4_WRITE;
            end
            RRNC_Q4_WRITE: begin
                if (dest_q) begin
                    wdata_d = res_q;
                    wr_d = 1'b1;
                end else begin
                    w_d = res_q;
                end
                fwe_d = 1'b1;
                done_d = 1'b1;
                active_d = 1'b0;
                phase_d = RRNC_Q1_DECODE;
            end
            default: begin
                phase_d = RRNC_Q1_DECODE;
                active_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_q <= RRNC_Q1_DECODE;
            active_q <= 1'b0;
            dest_q <= 1'b0;
            addr_q <= '0;
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            n_q <= 1'b0;
            z_q <= 1'b0;
            w_q <= RRNC_W_RESET;
            wdata_q <= 8'h00;
            wr_q <= 1'b0;
            fwe_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            active_q <= active_d;
            dest_q <= dest_d;
            addr_q <= addr_d;
            opnd_q <= opnd_d;
            res_q <= res_d;
            n_q <= n_d;
            z_q <= z_d;
            w_q <= w_d;
            wdata_q <= wdata_d;
            wr_q <= wr_d;
            fwe_q <= fwe_d;
            done_q <= done_d;
        end
    end

    assign busy = active_q;
    assign mem_addr = addr_q;
    // The read strobe is decoded from the phase so memory sees it within the read cycle.
    assign mem_rd = (phase_q == RRNC_Q2_READ);
    assign mem_wr = wr_q;
    assign mem_wdata = wdata_q;
    assign w_reg = w_q;
    assign n_flag = n_q;
    assign z_flag = z_q;
    assign flag_we = fwe_q;
    assign done = done_q;

    sequence s_launch;
        phase_q == RRNC_Q1_DECODE && start && rotate_right_nocarry_op;
    endsequence

    sequence s_walk;
        phase_q == RRNC_Q2_READ ##1 phase_q == RRNC_Q3_PROCESS ##1 phase_q == RRNC_Q4_WRITE;
    endsequence

    a_rotate_result: assert property (@(posedge ref_clk) disable iff (!nrst)
        phase_q == RRNC_Q3_PROCESS |=> res_q == {$past(opnd_q[0]), $past(opnd_q[7:1])})
        else $error("Rotated result does not match operand.");
    a_w_dest_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        phase_q == RRNC_Q4_WRITE && !dest_q |=> w_q == $past(res_q) && !mem_wr)
        else $error("Working register not written or memory disturbed.");
    a_mem_dest_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        phase_q == RRNC_Q4_WRITE && dest_q |=> mem_wr && mem_wdata == $past(res_q)
            && $stable(w_q) && mem_addr == $past(addr_q))
        else $error("Memory write-back missing or wrong.");
    a_access_bank: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch and !access_sel && !ext_set_en && f_addr < RRNC_ACCESS_SPLIT
            |=> mem_addr[RRNC_ADDR_W-1:8] == 4'h0)
        else $error("Access bank low half not selected.");
    a_bank_select: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch and access_sel |=> mem_addr == {$past(bank_select_reg), $past(f_addr)})
        else $error("Bank select not used for operand address.");
    a_indexed_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch and !access_sel && ext_set_en && f_addr <= RRNC_ILO_LIMIT
            |=> mem_addr == $past(index_base) + RRNC_ADDR_W'($past(f_addr)))
        else $error("Indexed literal offset address wrong.");
    a_four_phases: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch |=> s_walk ##1 done && phase_q == RRNC_Q1_DECODE)
        else $error("Instruction did not take four phases.");
    a_flag_update: assert property (@(posedge ref_clk) disable iff (!nrst)
        flag_we |-> n_flag == $past(res_q[7], 1) && z_flag == ($past(res_q, 1) == 8'h00))
        else $error("N or Z flag wrong after rotate.");
    a_access_upper: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch and !access_sel && f_addr >= RRNC_ACCESS_SPLIT
            |=> mem_addr == {RRNC_ACCESS_HI_BANK, $past(f_addr)})
        else $error("Access bank upper half not selected.");
    a_start_refused: assert property (@(posedge ref_clk) disable iff (!nrst)
        start && phase_q != RRNC_Q1_DECODE |=> $stable(mem_addr) && phase_q != RRNC_Q2_READ)
        else $error("Start accepted while the instruction was still running.");
    a_launch_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_launch |=> busy && mem_rd && !done)
        else $error("Read phase did not follow the decode phase.");
    a_done_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        done |=> !done && !flag_we && !mem_wr)
        else $error("Completion strobes lasted more than one cycle.");
    a_read_alone: assert property (@(posedge ref_clk) disable iff (!nrst)
        mem_rd |-> !mem_wr && !done && !flag_we)
        else $error("Read phase overlapped a write or completion.");
endmodule // rrnc_exec

// ==== test/rrnc_exec_test.sv ====
/* Self-checking bench for the rotate-right-without-carry execution unit.
   Assumes the unit's ports as declared and a 25 MHz core clock. */
module rrnc_exec_test
    import rrnc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst, start, op, dest_sel, access_sel, ext_set_en;
    logic busy, mem_rd, mem_wr, n_flag, z_flag, flag_we, done;
    logic [7:0] f_addr, mem_rdata, w_reg, mem_wdata, exp_w, exp_wd;
    logic [RRNC_BANK_W-1:0] bank_sel;
    logic [RRNC_ADDR_W-1:0] index_base, mem_addr;
    logic exp_wr, exp_n, exp_z;
    logic [RRNC_ADDR_W-1:0] exp_ea;
    int failures = 0;
    int checks_done = 0;
    rrnc_exec i_dut (.ref_clk(ref_clk), .nrst(nrst), .start(start),
        .rotate_right_nocarry_op(op), .f_addr(f_addr), .dest_sel(dest_sel),
        .access_sel(access_sel), .ext_set_en(ext_set_en), .bank_select_reg(bank_sel),
        .index_base(index_base), .mem_rdata(mem_rdata), .busy(busy), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .w_reg(w_reg),
        .n_flag(n_flag), .z_flag(z_flag), .flag_we(flag_we), .done(done));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check_end;
        #1;
        chk(done, 1'b1);
        chk(flag_we, 1'b1);
        chk(n_flag, exp_n);
        chk(z_flag, exp_z);
        chk(mem_wr, exp_wr);
        if (exp_wr) chk(mem_wdata, exp_wd);
        if (exp_wr) chk(mem_addr, exp_ea);
        chk(w_reg, exp_w);
        chk(busy, 1'b0);
    endtask
    // A chained call raises start in the done cycle, then judges the previous result.
    task run(input logic [7:0] f, input logic d, a, x, input logic [3:0] bk,
             input logic [11:0] base, input logic [7:0] data, input bit chain, hold);
        logic [7:0] res;
        logic [11:0] ea;
        res = {data[0], data[7:1]};
        if (a) ea = {bk, f};
        else if (x && f <= RRNC_ILO_LIMIT) ea = base + {4'h0, f};
        else if (f < RRNC_ACCESS_SPLIT) ea = {4'h0, f};
        else ea = {RRNC_ACCESS_HI_BANK, f};
        if (!chain) @(posedge ref_clk);
        start <= 1'b1;
        op <= 1'b1;
        f_addr <= f;
        dest_sel <= d;
        access_sel <= a;
        ext_set_en <= x;
        bank_sel <= bk;
        index_base <= base;
        mem_rdata <= data;
        if (chain) check_end();
        @(posedge ref_clk);
        start <= hold;
        #1;
        chk(busy, 1'b1);
        chk(mem_rd, 1'b1);
        chk(mem_addr, ea);
        @(posedge ref_clk);
        start <= 1'b0;
        // The read data is inverted once the read phase is over, so a late sample shows.
        mem_rdata <= ~data;
        #1;
        chk(mem_rd, 1'b0);
        repeat (2) @(posedge ref_clk);
        exp_ea = ea;
        exp_n = res[7];
        exp_z = (res == 8'h00);
        exp_wr = d;
        exp_wd = res;
        if (!d) exp_w = res;
    endtask
    task s_reset;
        #1;
        chk(busy, 1'b0);
        chk(done, 1'b0);
        chk(mem_wr, 1'b0);
        chk(flag_we, 1'b0);
        chk(w_reg, RRNC_W_RESET);
    endtask
    task s_refused;
        run(8'h10, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 8'h55, 1'b0, 1'b1);
        check_end();
        @(posedge ref_clk);
        #1;
        chk(done, 1'b0);
        chk(busy, 1'b0);
    endtask
    task s_access_w;
        run(8'h20, 1'b0, 1'b0, 1'b0, 4'hA, 12'h000, 8'hD7, 1'b0, 1'b0);
        check_end();
    endtask
    task s_bank_mem;
        run(8'hA0, 1'b1, 1'b1, 1'b0, 4'h5, 12'h000, 8'h01, 1'b0, 1'b0);
        check_end();
    endtask
    task s_access_high;
        run(8'h60, 1'b0, 1'b0, 1'b1, 4'h3, 12'h100, 8'h00, 1'b0, 1'b0);
        check_end();
    endtask
    task s_indexed_chain;
        run(8'h5F, 1'b1, 1'b0, 1'b1, 4'h2, 12'hFF0, 8'h80, 1'b0, 1'b0);
        run(8'h5F, 1'b0, 1'b1, 1'b1, 4'h7, 12'hFF0, 8'hFE, 1'b1, 1'b0);
        check_end();
    endtask
    task s_no_op;
        @(posedge ref_clk);
        start <= 1'b1;
        op <= 1'b0;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        chk(busy, 1'b0);
        chk(mem_rd, 1'b0);
    endtask
    initial begin
        {nrst, start, op, dest_sel, access_sel, ext_set_en} = 6'h00;
        f_addr = 8'h00;
        mem_rdata = 8'h00;
        bank_sel = 4'h0;
        index_base = 12'h000;
        exp_w = RRNC_W_RESET;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        s_reset();
        s_access_w();
        s_bank_mem();
        s_access_high();
        s_indexed_chain();
        s_refused();
        s_no_op();
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end
endmodule // rrnc_exec_test
